// ### rtl/divide_defs.vh
// Constants for the signed divide sequencer
`ifndef DIVIDE_DEFS_VH
`define DIVIDE_DEFS_VH

// Register byte offsets
`define OFS_CONTROL      8'h00
`define OFS_EVEN_PAIR    8'h04
`define OFS_ODD_PAIR     8'h08
`define OFS_DIVISOR      8'h0c
`define OFS_STATUS       8'h10

// Control register bits (write one to pulse)
`define CTL_START_BIT    0
`define CTL_SYNC_RST_BIT 1

// Status register fields
`define STS_C_BIT        0
`define STS_V_BIT        1
`define STS_Z_BIT        2
`define STS_N_BIT        3
`define STS_BUSY_BIT     4
`define STS_DONE_BIT     5
`define STS_QUIT_BIT     6

// Reset values
`define RST_WORD         16'h0000
`define RST_FLAGS        4'h0

// Pass counter load: octal 17 gives sixteen passes
`define PASS_LOAD        4'hf
`define PASS_ZERO        4'h0

// Most negative 16-bit pattern, octal 100000
`define MOST_NEG         16'h8000
`define WORD_ZERO        16'h0000

`endif

// ### rtl/alu_adder16.v
// Sixteen-bit adder with carry in and top carry out
`timescale 1ns/100ps

module alu_adder16
(
  input  wire [15:0] a_in,
  input  wire [15:0] b_in,
  input  wire        carry_in,
  output wire [15:0] sum,
  output wire        alu_top_carry
);

  wire [16:0] total;

  assign total = {1'b0, a_in} + {1'b0, b_in} + {16'h0000, carry_in};
  assign sum = total[15:0];
  assign alu_top_carry = total[16];

endmodule // alu_adder16

// ### rtl/pass_counter.v
// Divide loop pass counter
`timescale 1ns/100ps
`include "divide_defs.vh"

module pass_counter
(
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       clear,
  input  wire       load,
  input  wire       decrement,
  output reg  [3:0] count,
  output wire       at_zero
);

  assign at_zero = (count == `PASS_ZERO);

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      count <= `PASS_ZERO;
    else if (clear)
      count <= `PASS_ZERO;
    else if (load)
      count <= `PASS_LOAD;
    else if (decrement)
      count <= count - 4'h1;
  end

endmodule // pass_counter

// ### rtl/signed_divide_sequencer.v
// Microsequenced signed divide unit with register port
// What this block does
// - At start, load pass counter with octal 17 for sixteen passes.
// - Zero divisor skips division and sets Z, V and C.
// - Nonzero divisor: N takes the dividend sign bit.
// - Negative dividend negated as 32 bits, low word carry feeds high.
// - Negated dividend still negative aborts through overflow quit path.
// - Step shifts remainder with low top bit, adds or subtracts, shifts carry.
// - First step uses divisor sign only; later ones add quotient low bit.
// - After first step, a quotient over 16 bits quits the division.
// - Nonzero divisor passing overflow check clears C.
// - Loop repeats combined-criteria steps until counter reaches zero.
// - Remainder takes dividend sign, negated when dividend was negative.
// - Quotient positive when signs match, negative when they differ.
// - Quotient low bit zero corrects remainder by adding the divisor magnitude.
// - Remainder written to odd register, quotient to even, flags set.
// - Negative quotient is complement plus one, compared with 100000 octal.
// - Negated quotient equal to most negative value sets V.
// - Divisor is 16-bit source operand; results go odd and even.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "divide_defs.vh"

module signed_divide_sequencer
(
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [7:0]  address,
  input  wire [15:0] wr_data,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [15:0] rd_data,
  output reg         busy,
  output reg         done
);

  // ***********************************************
  // Sequencer states and storage
  // ***********************************************
  localparam [10:0] S_IDLE = 11'b000_0000_0001;
  localparam [10:0] S_ZCHK = 11'b000_0000_0010;
  localparam [10:0] S_NLO  = 11'b000_0000_0100;
  localparam [10:0] S_NHI  = 11'b000_0000_1000;
  localparam [10:0] S_STP1 = 11'b000_0001_0000;
  localparam [10:0] S_QCHK = 11'b000_0010_0000;
  localparam [10:0] S_LOOP = 11'b000_0100_0000;
  localparam [10:0] S_CORR = 11'b000_1000_0000;
  localparam [10:0] S_RSGN = 11'b001_0000_0000;
  localparam [10:0] S_QSGN = 11'b010_0000_0000;
  localparam [10:0] S_DONE = 11'b100_0000_0000;
  reg  [10:0] state;
  reg  [10:0] next_state;
  reg  [15:0] even_pair_register;
  reg  [15:0] odd_pair_register;
  reg  [15:0] divisor_source_register;
  reg  [15:0] partial_remainder_reg;
  reg  [15:0] quotient_shift_reg;
  reg  [15:0] divisor;
  reg  [3:0]  local_status_bits;
  reg         dividend_negative_flag;
  reg         write_back;
  reg         quit;
  reg         done_sticky;

  reg  [15:0] alu_a;
  reg  [15:0] alu_b;
  reg         alu_cin;
  reg         step_sub;
  wire [15:0] alu_sum;
  wire        alu_top_carry;
  wire        pass_zero;

  wire wr_hit_ctl;
  wire start_req;
  wire sync_rst_req;
  wire bus_free;
  wire divisor_zero;
  wire quot_negative;
  wire step_state;

  assign wr_hit_ctl   = wr_stb && (address == `OFS_CONTROL);
  assign start_req    = wr_hit_ctl && wr_data[`CTL_START_BIT];
  assign sync_rst_req = wr_hit_ctl && wr_data[`CTL_SYNC_RST_BIT];
  assign bus_free     = (state == S_IDLE);
  assign divisor_zero = (divisor == `WORD_ZERO);
  assign quot_negative = dividend_negative_flag ^ divisor[15];
  assign step_state   = (state == S_STP1) || (state == S_LOOP);

  // ***********************************************
  // Shared adder, pass counter, operand selection
  // ***********************************************
  alu_adder16 u_alu
  (
    .a_in          (alu_a),
    .b_in          (alu_b),
    .carry_in      (alu_cin),
    .sum           (alu_sum),
    .alu_top_carry (alu_top_carry)
  );

  pass_counter u_count
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clear     (sync_rst_req),
    .load      (state == S_IDLE && start_req && !sync_rst_req),
    .decrement (step_state),
    .count     (),
    .at_zero   (pass_zero)
  );
  always @*
  begin
    step_sub = 1'b0;
    alu_a    = `WORD_ZERO;
    alu_b    = `WORD_ZERO;
    alu_cin  = 1'b0;
    case (state)
      S_NLO:
      begin
        alu_a   = ~quotient_shift_reg;
        alu_cin = 1'b1;
      end
      S_NHI:
      begin
        alu_a   = ~partial_remainder_reg;
        alu_cin = local_status_bits[`STS_C_BIT];
      end
      S_STP1, S_LOOP:
      begin
        if (state == S_STP1)
          step_sub = ~divisor[15];
        else
          step_sub = quotient_shift_reg[0] ^ divisor[15];
        alu_a   = {partial_remainder_reg[14:0], quotient_shift_reg[15]};
        alu_b   = step_sub ? ~divisor : divisor;
        alu_cin = step_sub;
      end
      S_CORR:
      begin
        alu_a   = partial_remainder_reg;
        alu_b   = divisor[15] ? ~divisor : divisor;
        alu_cin = divisor[15];
      end
      S_RSGN:
      begin
        alu_a   = ~partial_remainder_reg;
        alu_cin = 1'b1;
      end
      S_QSGN:
      begin
        alu_a   = ~quotient_shift_reg;
        alu_cin = 1'b1;
      end
      default:
        alu_cin = 1'b0;
    endcase
  end

  // ***********************************************
  // Next state
  // ***********************************************
  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (start_req)
          next_state = S_ZCHK;
      S_ZCHK:
        if (divisor_zero)
          next_state = S_DONE;
        else if (partial_remainder_reg[15])
          next_state = S_NLO;
        else
          next_state = S_STP1;
      S_NLO:  next_state = S_NHI;
      S_NHI:
        if (alu_sum[15])
          next_state = S_DONE;
        else
          next_state = S_STP1;
      S_STP1: next_state = S_QCHK;
      S_QCHK:
        if (quotient_shift_reg[0])
          next_state = S_DONE;
        else
          next_state = S_LOOP;
      S_LOOP:
        if (pass_zero)
          next_state = S_CORR;
      S_CORR: next_state = S_RSGN;
      S_RSGN: next_state = S_QSGN;
      S_QSGN: next_state = S_DONE;
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
    if (sync_rst_req)
      next_state = S_IDLE;
  end

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // ***********************************************
  // Datapath and status bits
  // ***********************************************
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      partial_remainder_reg  <= `RST_WORD;
      quotient_shift_reg     <= `RST_WORD;
      divisor                <= `RST_WORD;
      local_status_bits      <= `RST_FLAGS;
      dividend_negative_flag <= 1'b0;
      write_back             <= 1'b0;
      quit                   <= 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE:
          if (start_req)
          begin
            partial_remainder_reg  <= even_pair_register;
            quotient_shift_reg     <= odd_pair_register;
            divisor                <= divisor_source_register;
            local_status_bits      <= `RST_FLAGS;
            dividend_negative_flag <= 1'b0;
            write_back             <= 1'b0;
            quit                   <= 1'b0;
          end
        S_ZCHK:
          if (divisor_zero)
          begin
            local_status_bits[`STS_Z_BIT] <= 1'b1;
            local_status_bits[`STS_V_BIT] <= 1'b1;
            local_status_bits[`STS_C_BIT] <= 1'b1;
          end
          else
          begin
            local_status_bits[`STS_N_BIT] <= partial_remainder_reg[15];
            dividend_negative_flag <= partial_remainder_reg[15];
          end
        S_NLO:
        begin
          quotient_shift_reg <= alu_sum;
          local_status_bits[`STS_C_BIT] <= alu_top_carry;
        end
        S_NHI:
        begin
          partial_remainder_reg <= alu_sum;
          if (alu_sum[15])
          begin
            local_status_bits[`STS_V_BIT] <= 1'b1;
            quit <= 1'b1;
          end
        end
        S_STP1, S_LOOP:
        begin
          partial_remainder_reg <= alu_sum;
          quotient_shift_reg <= {quotient_shift_reg[14:0], alu_top_carry};
        end
        S_QCHK:
          if (quotient_shift_reg[0])
          begin
            local_status_bits[`STS_V_BIT] <= 1'b1;
            quit <= 1'b1;
          end
          else
            local_status_bits[`STS_C_BIT] <= 1'b0;
        S_CORR:
          if (!quotient_shift_reg[0])
            partial_remainder_reg <= alu_sum;
        S_RSGN:
          if (dividend_negative_flag)
            partial_remainder_reg <= alu_sum;
        S_QSGN:
        begin
          write_back <= 1'b1;
          local_status_bits[`STS_V_BIT] <= 1'b0;
          if (quot_negative)
          begin
            quotient_shift_reg <= alu_sum;
            if (alu_sum == `MOST_NEG)
              local_status_bits[`STS_V_BIT] <= 1'b1;
          end
        end
        S_DONE:
          if (write_back)
          begin
            local_status_bits[`STS_N_BIT] <= quotient_shift_reg[15];
            local_status_bits[`STS_Z_BIT] <=
              (quotient_shift_reg == `WORD_ZERO);
          end
        default:
          write_back <= 1'b0;
      endcase
      if (sync_rst_req)
        write_back <= 1'b0;
    end
  end

  // ***********************************************
  // Bus writes, pair registers, busy, done, reads
  // ***********************************************
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      even_pair_register      <= `RST_WORD;
      odd_pair_register       <= `RST_WORD;
      divisor_source_register <= `RST_WORD;
    end
    else if (state == S_DONE && write_back)
    begin
      even_pair_register <= quotient_shift_reg;
      odd_pair_register  <= partial_remainder_reg;
    end
    else if (wr_stb && bus_free)
    begin
      if (address == `OFS_EVEN_PAIR)
        even_pair_register <= wr_data;
      if (address == `OFS_ODD_PAIR)
        odd_pair_register <= wr_data;
      if (address == `OFS_DIVISOR)
        divisor_source_register <= wr_data;
    end
  end
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy        <= 1'b0;
      done        <= 1'b0;
      done_sticky <= 1'b0;
      rd_data     <= `RST_WORD;
    end
    else
    begin
      busy <= (next_state != S_IDLE);
      done <= (state == S_DONE) && !sync_rst_req;
      if (state == S_DONE && !sync_rst_req)
        done_sticky <= 1'b1;
      else if (start_req || sync_rst_req)
        done_sticky <= 1'b0;
      rd_data <= `RST_WORD;
      if (rd_stb)
        case (address)
          `OFS_EVEN_PAIR: rd_data <= even_pair_register;
          `OFS_ODD_PAIR:  rd_data <= odd_pair_register;
          `OFS_DIVISOR:   rd_data <= divisor_source_register;
          `OFS_STATUS:
            rd_data <= {9'h000, quit, done_sticky, !bus_free,
                        local_status_bits};
          default:        rd_data <= `RST_WORD;
        endcase
    end
  end

endmodule // signed_divide_sequencer

// ### tb/divide_monitor.sv
// Port checker for the signed divide sequencer
`timescale 1ns/100ps

module divide_monitor
(
  input wire        clock,
  input wire        sys_rst,
  input wire [7:0]  address,
  input wire [15:0] wr_data,
  input wire        wr_stb,
  input wire        rd_stb,
  input wire [15:0] rd_data,
  input wire        busy,
  input wire        done
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  reg  [5:0] busy_len;
  wire       start;
  wire       srst;

  assign start = wr_stb && address == 8'h00 && wr_data[1:0] == 2'b01;
  assign srst  = wr_stb && address == 8'h00 && wr_data[1];

  // ****
  // Length of the current busy stretch
  // ****
  always @(posedge clock or posedge sys_rst)
    if (sys_rst)
      busy_len <= 6'h00;
    else
      busy_len <= busy ? busy_len + 6'h01 : 6'h00;

  start_busy_a: assert property (start && !busy |=> busy)
    else $error("busy did not follow a start");
  busy_min_a: assert property ($rose(busy) |-> busy ##1 busy)
    else $error("run shorter than two steps");
  busy_cap_a: assert property (busy_len <= 6'h18)
    else $error("run longer than the pass count allows");
  done_idle_a: assert property (done |-> !busy)
    else $error("done while busy");
  done_once_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  busy_end_a: assert property ($fell(busy) && !$past(srst) |-> done)
    else $error("run ended without done");
  done_cause_a: assert property (done |-> $past(busy))
    else $error("done without a run");
  read_quiet_a: assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
    else $error("read data outside the answer cycle");
endmodule // divide_monitor

bind signed_divide_sequencer divide_monitor u_mon
(
  .clock   (clock),
  .sys_rst (sys_rst),
  .address (address),
  .wr_data (wr_data),
  .wr_stb  (wr_stb),
  .rd_stb  (rd_stb),
  .rd_data (rd_data),
  .busy    (busy),
  .done    (done)
);

// ### tb/host_bus_model.sv
// Host side register bus master for the divide sequencer
`timescale 1ns/100ps

module host_bus_model
(
  input  wire        clock,
  input  wire [15:0] rd_data,
  output reg  [7:0]  address,
  output reg  [15:0] wr_data,
  output reg         wr_stb,
  output reg         rd_stb
);
  initial
  begin
    address = 8'h00;
    wr_data = 16'h0000;
    wr_stb  = 1'b0;
    rd_stb  = 1'b0;
  end

  task put_word(input [7:0] a, input [15:0] d);
  begin
    @(posedge clock);
    address <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clock);
    wr_stb  <= 1'b0;
  end
  endtask

  task get_word(input [7:0] a, output [15:0] d);
  begin
    @(posedge clock);
    address <= a;
    rd_stb  <= 1'b1;
    @(posedge clock);
    rd_stb  <= 1'b0;
    @(negedge clock);
    d = rd_data;
  end
  endtask
endmodule // host_bus_model

// ### tb/test_signed_divide_sequencer.sv
// Self-checking bench for the signed divide sequencer
`timescale 1ns/100ps

module test_signed_divide_sequencer;
  reg         clock;
  reg         sys_rst;
  wire [7:0]  address;
  wire [15:0] wr_data;
  wire        wr_stb;
  wire        rd_stb;
  wire [15:0] rd_data;
  wire        busy;
  wire        done;
  integer     failures;
  integer     cmp_count;
  reg  [15:0] v;

  signed_divide_sequencer dut
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .address (address),
    .wr_data (wr_data),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .rd_data (rd_data),
    .busy    (busy),
    .done    (done)
  );

  host_bus_model bus
  (
    .clock   (clock),
    .rd_data (rd_data),
    .address (address),
    .wr_data (wr_data),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb)
  );

  // ****
  // Shared tasks
  // ****
  task check(input string what, input [15:0] seen, input [15:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("Error %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task test_done;
  begin
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  task run_div(input [15:0] hi, input [15:0] lo, input [15:0] dv);
    reg signed [31:0] dd;
    reg signed [63:0] q;
    reg signed [63:0] r;
    reg [15:0] ev;
    reg [15:0] od;
    reg [15:0] fl;
    reg [15:0] msk;
    integer    n;
    integer    m;
  begin
    dd = {hi, lo};
    bus.put_word(8'h04, hi);
    bus.put_word(8'h08, lo);
    bus.put_word(8'h0c, dv);
    bus.put_word(8'h00, 16'h0001);
    n = 0;
    m = 0;
    repeat (40)
    begin
      @(negedge clock);
      if (busy === 1'b1)
        n = n + 1;
      if (done === 1'b1)
        m = m + 1;
    end
    ev = hi;
    od = lo;
    msk = 16'h002f;
    fl = 16'h0027;
    if (dv != 16'h0000)
    begin
      q = dd / $signed(dv);
      r = dd % $signed(dv);
      if (q > 32767 || q < -32768)
      begin
        msk = 16'h006e;
        fl = {9'h000, 3'b110, hi[15], 3'b010};
      end
      else
      begin
        ev = q[15:0];
        od = r[15:0];
        msk = 16'h007f;
        fl = {9'h000, 3'b010, q[15], q[15:0] == 16'h0000, q == -32768,
              1'b0};
        check("length", n[15:0], hi[15] ? 16'h0018 : 16'h0016);
      end
    end
    check("done pulse", m[15:0], 16'h0001);
    bus.get_word(8'h10, v);
    check("status", v & msk, fl);
    bus.get_word(8'h04, v);
    check("quotient", v, ev);
    bus.get_word(8'h08, v);
    check("remainder", v, od);
  end
  endtask

  // ****
  // Scenarios
  // ****
  task t_reset;
    reg [7:0] a;
  begin
    a = 8'h00;
    repeat (6)
    begin
      bus.get_word(a, v);
      check("reset read", v, 16'h0000);
      a = a + 8'h04;
    end
    $display("Test reset values done");
  end
  endtask

  task t_signs;
  begin
    run_div(16'h0000, 16'h0064, 16'h0007);
    run_div(16'hffff, 16'hff9c, 16'h0007);
    run_div(16'h0000, 16'h0064, 16'hfff9);
    run_div(16'hffff, 16'hff9c, 16'hfff9);
    run_div(16'h0000, 16'h0006, 16'h0003);
    run_div(16'h0000, 16'h0000, 16'h0005);
    $display("Test sign combinations done");
  end
  endtask

  task t_long;
  begin
    run_div(16'h0001, 16'h0000, 16'h0003);
    run_div(16'hffff, 16'h0000, 16'h0003);
    run_div(16'h0000, 16'h7fff, 16'h0001);
    $display("Test long quotients done");
  end
  endtask

  task t_faults;
  begin
    run_div(16'h1234, 16'h5678, 16'h0000);
    run_div(16'h8000, 16'h0000, 16'h0005);
    run_div(16'h0010, 16'h0000, 16'h0002);
    run_div(16'hfff0, 16'h0000, 16'hfffe);
    $display("Test fault paths done");
  end
  endtask

  task t_guard;
  begin
    bus.put_word(8'h04, 16'h0000);
    bus.put_word(8'h08, 16'h0064);
    bus.put_word(8'h0c, 16'h0007);
    bus.put_word(8'h00, 16'h0001);
    bus.put_word(8'h04, 16'h1234);
    bus.put_word(8'h0c, 16'h0001);
    repeat (30) @(posedge clock);
    bus.get_word(8'h04, v);
    check("busy write", v, 16'h000e);
    bus.get_word(8'h0c, v);
    check("busy divisor", v, 16'h0007);
    bus.put_word(8'h04, 16'h0000);
    bus.put_word(8'h00, 16'h0001);
    repeat (5) @(posedge clock);
    @(negedge clock);
    check("sync busy", {15'h0000, busy}, 16'h0001);
    bus.put_word(8'h00, 16'h0002);
    @(negedge clock);
    check("sync idle", {15'h0000, busy}, 16'h0000);
    bus.get_word(8'h10, v);
    check("sync status", v & 16'h0030, 16'h0000);
    bus.get_word(8'h04, v);
    check("sync keep", v, 16'h0000);
    run_div(16'h0000, 16'h0064, 16'h0007);
    $display("Test busy guard and sync reset done");
  end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial
  begin
    #(25 * 8000);
    failures = failures + 1;
    test_done;
  end

  initial
  begin
    failures = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset;
    t_signs;
    t_long;
    t_faults;
    t_guard;
    test_done;
  end
endmodule // test_signed_divide_sequencer
